// [rtl/flr_pkg.sv]
// Purpose: shared constants and types for the fault logger and reset block
// Assumes: one system clock, synchronous active-low reset
// Notes:   fault identities are small integers, 0 is the fault on cause bit 0
package flr_pkg;
  localparam int NUM_FAULTS    = 16;
  localparam int FAULT_W       = 4;
  localparam int HIST_DEPTH    = 16;
  localparam int HIST_PTR_W    = 4;
  localparam int COUNT_W       = 16;
  localparam int STAMP_W       = 36;   // month4 day5 year7 hour5 min6 sec6 plus spare
  localparam int NUM_OUTS      = 4;

  // clear request source selection
  localparam logic [1:0] SRC_INPUT  = 2'h0;
  localparam logic [1:0] SRC_SERIAL = 2'h1;
  localparam logic [1:0] SRC_AUTO   = 2'h2;
  localparam logic [1:0] SRC_KEYPAD = 2'h3;

  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;

  typedef enum logic [2:0]
  {
    FLR_STOPPED = 3'b001,
    FLR_RUNNING = 3'b010,
    FLR_WAIT_CY = 3'b100
  } flr_run_t;
endpackage

// [rtl/flr_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to I_CLK
// Notes:   the first stage feeds only the second
`timescale 1ns/10ps
module flr_sync #(parameter int W = 4)
(
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  flr_sync_if.sync    io
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } flr_sync_st_t;

  flr_sync_st_t st;
  flr_sync_st_t next_st;

  // a level only moves once stages two and three agree, filtering a one-cycle glitch
  always_comb
  begin
    next_st    = st;
    next_st.s1 = io.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
        next_st.level[i] = st.s3[i];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign io.level = st.level;
endmodule

// [rtl/flr_sync_if.sv]
// Purpose: carrier between the top and the pin synchroniser
// Assumes: width set by the instantiating module
// Notes:   raw pins in, agreed levels out
`timescale 1ns/10ps
interface flr_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface

// [rtl/flr_top.sv]
// Purpose: fault manager: active list, history, counts, run lockout, display, resets
// Assumes: fault causes and commands are synchronous pulses or levels on I_CLK,
//          run request and reset input come from pins
// Notes:   history arrays are held in flops; nonvolatile storage is outside
//
// Contract
// - a detected fault enters the active list and stays until an active-list reset.
// - the last 16 faults are kept with their identity and time stamp, only the lowest identity when several arrive in one cycle.
// - history survives an active-list reset; only a history clear erases it.
// - a history clear erases the history and all occurrence counts together.
// - every fault type counts its occurrences since the last history clear.
// - counts are presented ordered with the largest count first.
// - each stamp holds month, day, year, hour, minute and second from the time clock.
// - while any fault is present the drive is stopped and may not start.
// - a new fault shows a priority message, a keypress dismisses it, the next follows.
// - dismissing a message leaves the active list unchanged.
// - a reset is accepted from the input, the serial channel, automatic reset or keypad.
// - if run is requested when a reset takes effect the drive runs at once.
// - with automatic reset the run request must be cycled before running again.
// - a configurable map drives each logic output while a selected fault is present.
// - after a reset a fault whose cause persists stays reported and lit.
`timescale 1ns/10ps
module flr_top
#(
  parameter int NF = flr_pkg::NUM_FAULTS,
  parameter int HD = flr_pkg::HIST_DEPTH
)
(
  input  wire logic                          I_CLK,
  input  wire logic                          I_RESETN,
  input  wire logic [NF-1:0]                 i_fault_cause,
  input  wire logic [flr_pkg::STAMP_W-1:0]   i_time_of_day,
  input  wire logic                          i_run_request_pin,
  input  wire logic                          i_reset_pin,
  input  wire logic                          i_serial_reset,
  input  wire logic                          i_keypad_reset,
  input  wire logic                          i_keypress,
  input  wire logic                          i_history_clear,
  input  wire logic [1:0]                    i_clear_request_source_select,
  input  wire logic [flr_pkg::NUM_OUTS*NF-1:0] i_out_map,
  input  wire logic [flr_pkg::HIST_PTR_W-1:0] i_hist_sel,
  input  wire logic [flr_pkg::FAULT_W-1:0]   i_rank_sel,
  output logic [NF-1:0]                      o_active,
  output logic                               o_fault_led,
  output logic                               o_drive_run,
  output logic                               o_msg_valid,
  output logic [flr_pkg::FAULT_W-1:0]        o_msg_fault,
  output logic [flr_pkg::NUM_OUTS-1:0]       o_logic_out,
  output logic [flr_pkg::FAULT_W-1:0]        o_hist_fault,
  output logic [flr_pkg::STAMP_W-1:0]        o_hist_stamp,
  output logic [4:0]                         o_hist_count,
  output logic [flr_pkg::FAULT_W-1:0]        o_rank_fault,
  output logic [flr_pkg::COUNT_W-1:0]        o_rank_count
);
  localparam int FW = flr_pkg::FAULT_W;
  localparam int CW = flr_pkg::COUNT_W;
  localparam int PW = flr_pkg::HIST_PTR_W;
  localparam int NO = flr_pkg::NUM_OUTS;

  // the decoders index by bit position, so the counts must fill the widths exactly
  if (NF != (1 << FW) || HD != (1 << PW))
  begin
    $error("flr_top: fault count and history depth must match the package widths");
  end

  default clocking cb_chk @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  typedef struct packed
  {
    logic [NF-1:0]                     cause_q;
    logic [NF-1:0]                     active;
    logic [NF-1:0]                     pending;
    logic [HD-1:0][FW-1:0]             hist_id;
    logic [HD-1:0][flr_pkg::STAMP_W-1:0] hist_ts;
    logic [PW-1:0]                     wr_ptr;
    logic [4:0]                        fill;
    logic [NF-1:0][CW-1:0]             count;
    logic [NF-1:0][FW-1:0]             rank;
    flr_pkg::flr_run_t                 run;
    logic                              msg_valid;
    logic [FW-1:0]                     msg_fault;
    logic [NO-1:0]                     outs;
    logic                              led;
    logic                              reset_q;     // filtered reset pin level one cycle back
    logic [FW-1:0]                     hist_fault;
    logic [flr_pkg::STAMP_W-1:0]       hist_stamp;
    logic [FW-1:0]                     rank_fault;
    logic [CW-1:0]                     rank_count;
  } flr_st_t;

  flr_st_t st;
  flr_st_t next_st;

  flr_sync_if #(.W(2)) pins();
  assign pins.raw = {i_reset_pin, i_run_request_pin};

  flr_sync #(.W(2)) u_sync
  (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .io       (pins.sync)
  );

  logic run_req;
  logic reset_lvl;
  assign run_req   = pins.level[0];
  assign reset_lvl = pins.level[1];

  // lowest set bit as fault identity
  function automatic logic [FW-1:0] first_set(input logic [NF-1:0] v);
    logic [FW-1:0] r;
    r = '0;
    for (int i = NF - 1; i >= 0; i--)
    begin
      if (v[i])
        r = FW'(i);
    end
    return r;
  endfunction

  logic [NF-1:0] new_fault;
  logic          do_reset;
  logic          fault_now;
  logic          auto_src;
  assign new_fault = i_fault_cause & ~st.cause_q;
  assign auto_src  = (i_clear_request_source_select == flr_pkg::SRC_AUTO);

  // each source only counts when selected, so two channels cannot fight
  always_comb
  begin
    unique case (i_clear_request_source_select)
      flr_pkg::SRC_INPUT:  do_reset = reset_lvl & ~st.reset_q;
      flr_pkg::SRC_SERIAL: do_reset = i_serial_reset;
      flr_pkg::SRC_AUTO:   do_reset = |st.active & ~|(i_fault_cause);
      default:             do_reset = i_keypad_reset;
    endcase
  end

  logic [NF-1:0] next_active;
  // a still-present cause sets again in the reset cycle, so set wins over clear
  assign next_active = (do_reset ? '0 : st.active) | i_fault_cause;
  assign fault_now   = |next_active;

  always_comb
  begin
    logic [FW-1:0] id;
    logic [FW-1:0] tmp;
    id       = first_set(new_fault);
    tmp      = '0;
    next_st  = st;
    next_st.cause_q = i_fault_cause;
    next_st.active  = next_active;
    next_st.led     = fault_now;
    next_st.reset_q = reset_lvl;
    // readout trails the store by one cycle; select 0 is the newest entry
    next_st.hist_fault = st.hist_id[st.wr_ptr - PW'(1) - i_hist_sel];
    next_st.hist_stamp = st.hist_ts[st.wr_ptr - PW'(1) - i_hist_sel];
    next_st.rank_fault = st.rank[i_rank_sel];
    next_st.rank_count = st.count[st.rank[i_rank_sel]];
    // history is never touched by an active-list reset; only the clear command erases it
    if (i_history_clear)
    begin
      next_st.wr_ptr = '0;
      next_st.fill   = '0;
      next_st.count  = '0;
      next_st.hist_id = '0;
      next_st.hist_ts = '0;
    end
    else if (|new_fault)
    begin
      next_st.hist_id[st.wr_ptr] = id;
      next_st.hist_ts[st.wr_ptr] = i_time_of_day;
      next_st.wr_ptr = st.wr_ptr + PW'(1);
      if (st.fill != 5'(HD))
        next_st.fill = st.fill + 5'h1;
      for (int i = 0; i < NF; i++)
      begin
        if (new_fault[i] && st.count[i] != flr_pkg::COUNT_MAX)
          next_st.count[i] = st.count[i] + CW'(1);
      end
    end
    // one odd-even bubble pass per cycle keeps the ranking sorted largest first
    for (int i = 0; i + 1 < NF; i += 2)
    begin
      if (st.count[st.rank[i+1]] > st.count[st.rank[i]])
      begin
        tmp = next_st.rank[i];
        next_st.rank[i]   = next_st.rank[i+1];
        next_st.rank[i+1] = tmp;
      end
    end
    for (int i = 1; i + 1 < NF; i += 2)
    begin
      if (st.count[next_st.rank[i+1]] > st.count[next_st.rank[i]])
      begin
        tmp = next_st.rank[i];
        next_st.rank[i]   = next_st.rank[i+1];
        next_st.rank[i+1] = tmp;
      end
    end
    // priority message: new faults queue, a keypress shows the next
    next_st.pending = (st.pending | new_fault) & next_active;
    if (|new_fault)
    begin
      next_st.msg_valid = 1'b1;
      next_st.msg_fault = id;
      next_st.pending   = next_st.pending & ~new_fault | (new_fault & ~(NF'(1) << id));
    end
    else if (st.msg_valid && i_keypress)
    begin
      next_st.msg_valid = |st.pending;
      next_st.msg_fault = first_set(st.pending);
      next_st.pending   = st.pending & ~(NF'(1) << first_set(st.pending));
    end
    else if (!st.msg_valid && |st.pending)
    begin
      next_st.msg_valid = 1'b1;
      next_st.msg_fault = first_set(st.pending);
      next_st.pending   = st.pending & ~(NF'(1) << first_set(st.pending));
    end
    for (int k = 0; k < NO; k++)
      next_st.outs[k] = |(next_active & i_out_map[k*NF +: NF]);
    // run control
    unique case (st.run)
      flr_pkg::FLR_STOPPED:
        if (!fault_now && run_req)
          next_st.run = (auto_src && do_reset) ? flr_pkg::FLR_WAIT_CY
                                               : flr_pkg::FLR_RUNNING;
      flr_pkg::FLR_RUNNING:
        if (fault_now)
          next_st.run = flr_pkg::FLR_STOPPED;
        else if (!run_req)
          next_st.run = flr_pkg::FLR_STOPPED;
      flr_pkg::FLR_WAIT_CY:
        if (fault_now || !run_req)
          next_st.run = flr_pkg::FLR_STOPPED;
      default:
        next_st.run = flr_pkg::FLR_STOPPED;
    endcase
    if (st.run == flr_pkg::FLR_STOPPED && auto_src && run_req && st.led)
      next_st.run = flr_pkg::FLR_WAIT_CY;
  end

  // the rank list starts as the identity order
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      st     <= '0;
      st.run <= flr_pkg::FLR_STOPPED;
      for (int i = 0; i < NF; i++)
        st.rank[i] <= FW'(i);
    end
    else
      st <= next_st;
  end

  assign o_active     = st.active;
  assign o_hist_fault = st.hist_fault;
  assign o_hist_stamp = st.hist_stamp;
  assign o_rank_fault = st.rank_fault;
  assign o_rank_count = st.rank_count;
  assign o_fault_led  = st.led;
  assign o_drive_run  = st.run[1];
  assign o_msg_valid  = st.msg_valid;
  assign o_msg_fault  = st.msg_fault;
  assign o_logic_out  = st.outs;
  assign o_hist_count = st.fill;

  // checks run on the default clock and sleep through reset
  property p_latch;
    (|i_fault_cause) |=> (st.active & $past(i_fault_cause)) == $past(i_fault_cause);
  endproperty
  a_latch: assert property (p_latch) else $error("fault not latched");
  property p_hold;
    (!do_reset && |st.active) |=> (st.active & $past(st.active)) == $past(st.active);
  endproperty
  a_hold: assert property (p_hold) else $error("active fault lost");
  property p_lock;
    (|st.active) |-> !o_drive_run;
  endproperty
  a_lock: assert property (p_lock) else $error("running with fault");
  property p_clear;
    i_history_clear |=> (st.fill == 5'h0 && st.count == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("history not cleared");
  property p_count;
    (!i_history_clear && new_fault[0] && st.count[0] != flr_pkg::COUNT_MAX)
      |=> st.count[0] == $past(st.count[0]) + CW'(1);
  endproperty
  a_count: assert property (p_count) else $error("count missed");
  property p_stamp;
    (!i_history_clear && |new_fault) |=> st.hist_ts[$past(st.wr_ptr)] == $past(i_time_of_day);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp wrong");
  property p_keep;
    (do_reset && !i_history_clear && !(|new_fault)) |=> st.fill == $past(st.fill);
  endproperty
  a_keep: assert property (p_keep) else $error("history disturbed");
  property p_msg;
    (|new_fault) |=> o_msg_valid;
  endproperty
  a_msg: assert property (p_msg) else $error("no priority message");
  property p_persist;
    (do_reset && |i_fault_cause) |=> o_fault_led;
  endproperty
  a_persist: assert property (p_persist) else $error("persisting fault dark");
  property p_full;
    st.fill <= 5'(HD);
  endproperty
  a_full: assert property (p_full) else $error("history overfilled");

  // main scenarios: run after a reset, a full history, a dismissal with more queued
  c_reset_run: cover property (do_reset ##[1:8] o_drive_run);
  c_full:      cover property (st.fill == 5'(HD));
  c_dismiss:   cover property ((o_msg_valid && i_keypress) ##1 o_msg_valid);
endmodule

// [tb/flr_far_model.sv]
// Purpose: far side of the fault block: controller run request and operator keypad
// Assumes: every line changes on the falling edge of the system clock
// Notes:   run request is a level; a key and the keypad clear are one-cycle pulses
`timescale 1ns/10ps
module flr_far_model
(
  input  wire logic i_clk,
  output logic      o_run_request,
  output logic      o_keypress,
  output logic      o_keypad_reset
);
  // all lines quiet at time zero
  initial
  begin
    o_run_request = 1'b0;
    o_keypress = 1'b0;
    o_keypad_reset = 1'b0;
  end

  // run request is a level held until the controller changes it
  task automatic set_run(input logic v);
    @(negedge i_clk);
    o_run_request = v;
  endtask

  // after an automatic clear the run request must be dropped, then raised
  task automatic cycle_run();
    set_run(1'b0);
    repeat (6) @(negedge i_clk);
    set_run(1'b1);
  endtask

  // one-cycle pulse; clr picks the keypad clear key instead of any key
  task automatic key(input bit clr);
    @(negedge i_clk);
    o_keypress = !clr;
    o_keypad_reset = clr;
    @(negedge i_clk);
    o_keypress = 1'b0;
    o_keypad_reset = 1'b0;
  endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the fault logger and reset block
// Assumes: inputs change on the falling edge, outputs settle one cycle later
// Notes:   ranking needs several cycles to settle, so rank checks wait a while
`timescale 1ns/10ps
module tb_top;
  logic                                   clk;
  logic                                   resetn;
  logic [15:0]                            cause;
  logic [flr_pkg::STAMP_W-1:0]            tod;
  logic                                   run_pin;
  logic                                   reset_pin;
  logic                                   serial_reset;
  logic                                   key_press;
  logic                                   keypad_reset;
  logic                                   hist_clear;
  logic [1:0]                             src;
  logic [63:0]                            out_map;
  logic [3:0]                             hist_sel;
  logic [3:0]                             rank_sel;
  logic [15:0]                            active;
  logic                                   led;
  logic                                   drive_run;
  logic                                   msg_valid;
  logic [3:0]                             msg_fault;
  logic [3:0]                             logic_out;
  logic [3:0]                             hist_fault;
  logic [flr_pkg::STAMP_W-1:0]            hist_stamp;
  logic [4:0]                             hist_count;
  logic [3:0]                             rank_fault;
  logic [15:0]                            rank_count;
  int                                     n_fail;
  int                                     total_checks;

  flr_top flr_top_inst (.I_CLK(clk), .I_RESETN(resetn), .i_fault_cause(cause),
    .i_time_of_day(tod), .i_run_request_pin(run_pin), .i_reset_pin(reset_pin),
    .i_serial_reset(serial_reset), .i_keypad_reset(keypad_reset), .i_keypress(key_press),
    .i_history_clear(hist_clear), .i_clear_request_source_select(src),
    .i_out_map(out_map), .i_hist_sel(hist_sel), .i_rank_sel(rank_sel),
    .o_active(active), .o_fault_led(led), .o_drive_run(drive_run),
    .o_msg_valid(msg_valid), .o_msg_fault(msg_fault), .o_logic_out(logic_out),
    .o_hist_fault(hist_fault), .o_hist_stamp(hist_stamp), .o_hist_count(hist_count),
    .o_rank_fault(rank_fault), .o_rank_count(rank_count));

  flr_far_model flr_far_model_inst (.i_clk(clk), .o_run_request(run_pin),
    .o_keypress(key_press), .o_keypad_reset(keypad_reset));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait on the run output; running out of time ends the run
  task automatic wait_run(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && drive_run !== v; i++) cyc(1);
    check("drive_run", drive_run, v);
    if (drive_run !== v) stop_test();
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask

  // one new fault, stamped with the given time
  task automatic fault(input int id, input int stamp);
    tod = 36'(stamp);
    cause[id] = 1'b1;
    cyc(1);
    cause[id] = 1'b0;
    cyc(1);
  endtask

  // running drive stops on a fault; message dismissal keeps the list
  task automatic t_walk();
    flr_far_model_inst.set_run(1'b1);
    wait_run(1'b1, 12);
    cause[3] = 1'b1;
    cyc(2);
    check("active3", active[3], 1'b1);
    check("led", led, 1'b1);
    check("msg_valid", msg_valid, 1'b1);
    check("msg_fault", msg_fault, 4'h3);
    check("run_stop", drive_run, 1'b0);
    flr_far_model_inst.key(1'b0);
    cause[3] = 1'b0;
    cyc(2);
    check("msg_gone", msg_valid, 1'b0);
    check("active_kept", active[3], 1'b1);
    check("run_refused", drive_run, 1'b0);
    pulse(serial_reset);
    check("active_clr", active, 16'h0000);
    wait_run(1'b1, 3);
    flr_far_model_inst.set_run(1'b0);
    wait_run(1'b0, 10);
  endtask

  // a reset while the cause persists leaves it reported; other sources
  task automatic t_persist();
    src = flr_pkg::SRC_KEYPAD;
    cause[4] = 1'b1;
    cyc(2);
    flr_far_model_inst.key(1'b1);
    cyc(1);
    check("persist", active[4], 1'b1);
    check("led_lit", led, 1'b1);
    cause[4] = 1'b0;
    src = flr_pkg::SRC_INPUT;
    cyc(1);
    // the pin filter drops a one-cycle pulse, so the request is held a few cycles
    reset_pin = 1'b1;
    cyc(4);
    reset_pin = 1'b0;
    cyc(8);
    check("pin_clr", active, 16'h0000);
    check("led_off", led, 1'b0);
    flr_far_model_inst.key(1'b0);
  endtask

  // two faults at once: lowest first, next after a key; mapped outputs
  task automatic t_map();
    src = flr_pkg::SRC_SERIAL;
    cause[6] = 1'b1;
    cause[10] = 1'b1;
    // output 1 follows fault 6, output 3 follows fault 10
    out_map = {cause & 16'h0400, 16'h0000, cause & 16'h0040, 16'h0000};
    cyc(2);
    check("msg_first", msg_fault, 4'h6);
    check("outs", logic_out, 4'ha);
    flr_far_model_inst.key(1'b0);
    cyc(1);
    check("msg_next", msg_valid, 1'b1);
    check("msg_next_id", msg_fault, 4'ha);
    flr_far_model_inst.key(1'b0);
    cause[6] = 1'b0;
    cause[10] = 1'b0;
    pulse(serial_reset);
    check("outs_off", logic_out, 4'h0);
  endtask

  // 17 faults into 16 places: the oldest falls out, stamps follow
  task automatic t_history();
    int i;
    pulse(hist_clear);
    check("hist_empty", hist_count, 5'h00);
    for (i = 0; i < 17; i++) fault((i % 15) + 1, i);
    cyc(2);
    check("hist_full", hist_count, 5'h10);
    // select i reads the entry written by fault number 16 - i
    for (i = 0; i < 16; i++)
    begin
      hist_sel = 4'(i);
      cyc(3);
      check("hist_id", hist_fault, 36'(((16 - i) % 15) + 1));
      check("hist_stamp", hist_stamp, 36'(16 - i));
      if (i == 15) check("old_stamp", hist_stamp, 36'h0_0000_0001);
    end
    pulse(serial_reset);
    check("hist_kept", hist_count, 5'h10);
  endtask

  // counts per fault, largest first, erased with the history
  task automatic t_rank();
    int i;
    pulse(hist_clear);
    fault(7, 0);
    repeat (3) fault(5, 0);
    cyc(24);
    // fault 5 three times, fault 7 once, every other type never
    for (i = 0; i < 16; i++)
    begin
      rank_sel = 4'(i);
      cyc(3);
      if (i == 0) check("rank0_id", rank_fault, 4'h5);
      if (i == 0) check("rank0_cnt", rank_count, 16'h0003);
      if (i == 1) check("rank1_id", rank_fault, 4'h7);
      if (i == 1) check("rank1_cnt", rank_count, 16'h0001);
      if (i > 1) check("rank_tail", rank_count, 16'h0000);
    end
    pulse(hist_clear);
    rank_sel = 4'h0;
    cyc(24);
    check("rank_clr", rank_count, 16'h0000);
    check("hist_clr", hist_count, 5'h00);
    pulse(serial_reset);
  endtask

  // automatic clear: the run request must be cycled before running again
  task automatic t_auto();
    src = flr_pkg::SRC_AUTO;
    flr_far_model_inst.set_run(1'b1);
    // the run request must clear the pin filter first, so the fault meets a running drive
    wait_run(1'b1, 12);
    fault(9, 0);
    cyc(4);
    check("auto_clr", active, 16'h0000);
    cyc(10);
    check("auto_hold", drive_run, 1'b0);
    flr_far_model_inst.cycle_run();
    wait_run(1'b1, 12);
  endtask

  // main sequence
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    resetn = 1'b0;
    {cause, tod, reset_pin, serial_reset, hist_clear} = '0;
    src = flr_pkg::SRC_SERIAL;
    out_map = '0;
    hist_sel = 4'h0;
    rank_sel = 4'h0;
    cyc(12);
    resetn = 1'b1;
    cyc(1);
    check("rst_active", active, 16'h0000);
    check("rst_run", drive_run, 1'b0);
    t_walk();
    t_persist();
    t_map();
    t_history();
    t_rank();
    t_auto();
    stop_test();
  end
endmodule
